// ---- core/ssio_status_io.sv ----
// supply status i/o: fault state, fault clear, status pins, contact drive
// assumes asynchronous isolated pins and an avalon-mm master on clk
//
// Behaviour
// - a qualified fault-clear pulse acts only in the fault state.
// - an accepted clear resumes operation unless the fault persists.
// - auto restart and software clear also act only in the fault state.
// - bus ready is on only when operational and no fault present.
// - a fault that opens the contact turns bus ready off.
// - line present is on while ac input above minimum is detected.
// - line present turns off about 20 ms after ac input loss.
// - fault output is on with the dc bus disabled on any fault.
// - any fault opens the ready-to-operate contact.
// - brake energy overload moves operation to fault and opens the contact.
`timescale 1ns/10ps
`include "ssio_map.svh"
module ssio_status_io
  import ssio_pkg::*;
#(
  parameter int unsigned CLR_MIN_CYC = `SSIO_CLR_MIN_CYC,
  parameter int unsigned LINE_OFF_CYC = `SSIO_LINE_OFF_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // isolated inputs
  input wire logic faultClearInput,
  input wire logic acLineDetect,
  input wire logic faultDetect,
  input wire logic brakeOverload,
  // isolated status outputs and contact
  output logic busReadyOutput,
  output logic linePresentOutput,
  output logic faultIndicatorOutput,
  output logic readyToOperateContact,
  output logic highVoltageDcBusEnable,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt
  output logic irq
);

  ssio_clr_if clrIf ();

  ssio_pulse_qual #(
    .MIN_CYC(CLR_MIN_CYC)
  ) uQual (
    .clk(clk),
    .srst(srst),
    .pinAsync(faultClearInput),
    .clr(clrIf.qual)
  );

  // level pins: three stages, a change counts once stages 1 and 2 agree
  logic [`SSIO_PIN_N-1:0] pinRaw;
  logic [`SSIO_PIN_N-1:0] pinLvl_q;

  assign pinRaw[`SSIO_PIN_LINE] = acLineDetect;
  assign pinRaw[`SSIO_PIN_FAULT] = faultDetect;
  assign pinRaw[`SSIO_PIN_BRAKE] = brakeOverload;

  genvar gi;
  generate
    for (gi = 0; gi < `SSIO_PIN_N; gi++)
    begin : gSync
      logic [2:0] sync_q;
      logic lvl_q;
      always_ff @(posedge clk)
      begin
        if (srst)
          sync_q <= 3'h0;
        else
          sync_q <= {sync_q[1:0], pinRaw[gi]};
      end
      // one flop per loop pass, so no vector has several clocked writers
      always_ff @(posedge clk)
      begin
        if (srst)
          lvl_q <= 1'b0;
        else if (sync_q[1] == sync_q[2])
          lvl_q <= sync_q[2];
      end
      assign pinLvl_q[gi] = lvl_q;
    end
  endgenerate

  logic acLvl;
  logic brakeLvl;
  logic faultNow;

  assign acLvl = pinLvl_q[`SSIO_PIN_LINE];
  assign brakeLvl = pinLvl_q[`SSIO_PIN_BRAKE];
  assign faultNow = pinLvl_q[`SSIO_PIN_FAULT] || brakeLvl;

  // register state
  logic swClear_q;
  logic autoRestart_q;
  logic [`SSIO_IRQ_W-1:0] irqStat_q;
  logic [`SSIO_IRQ_W-1:0] irqStat_d;
  logic [`SSIO_IRQ_W-1:0] irqMask_q;
  logic [31:0] readData_q;
  logic waitReq_q;
  logic irq_q;

  // fault state machine
  ssio_state_t state_q;
  ssio_state_t state_d;
  logic anyClear;

  // clear sources are only looked at from the fault state
  assign anyClear = clrIf.accept || swClear_q || autoRestart_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSIO_INIT:
        state_d = faultNow ? SSIO_FAULT : SSIO_OPER;
      SSIO_OPER:
        if (faultNow)
          state_d = SSIO_FAULT;
      SSIO_FAULT:
        if (anyClear && !faultNow)
          state_d = SSIO_OPER;
      default:
        state_d = SSIO_INIT;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_q <= SSIO_INIT;
    else
      state_q <= state_d;
  end

  // status pins and contact
  logic busReady_q;
  logic faultOut_q;
  logic contact_q;
  logic hvdcEn_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      busReady_q <= 1'b0;
      faultOut_q <= 1'b0;
      contact_q <= 1'b0;
      hvdcEn_q <= 1'b0;
    end
    else
    begin
      busReady_q <= (state_q == SSIO_OPER) && !faultNow;
      faultOut_q <= (state_q == SSIO_FAULT);
      contact_q <= (state_q == SSIO_OPER);
      hvdcEn_q <= (state_q == SSIO_OPER);
    end
  end

  // line present with off delay
  logic linePresent_q;
  logic [31:0] lineCnt_q;

  always_ff @(posedge clk)
  begin
    if (srst || acLvl)
      lineCnt_q <= 32'h0;
    else if (linePresent_q)
      lineCnt_q <= lineCnt_q + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      linePresent_q <= 1'b0;
    else if (acLvl)
      linePresent_q <= 1'b1;
    else if (lineCnt_q == LINE_OFF_CYC - 32'h1)
      linePresent_q <= 1'b0;
  end

  // bus slave: answers one cycle after a request is seen
  logic busHit;
  logic wrCtrl;
  logic wrMask;
  logic rdIrq;

  assign busHit = (read || write) && waitReq_q;
  assign wrCtrl = busHit && write && (address == `SSIO_OFS_CTRL);
  assign wrMask = busHit && write && (address == `SSIO_OFS_IRQ_MASK);
  assign rdIrq = busHit && read && (address == `SSIO_OFS_IRQ_STAT);

  always_ff @(posedge clk)
  begin
    if (srst)
      waitReq_q <= 1'b1;
    else
      waitReq_q <= !busHit;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      swClear_q <= 1'b0;
      autoRestart_q <= 1'b0;
    end
    else
    begin
      swClear_q <= wrCtrl && writedata[`SSIO_CTRL_CLEAR];
      if (wrCtrl)
        autoRestart_q <= writedata[`SSIO_CTRL_AUTO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irqMask_q <= '0;
    else if (wrMask)
      irqMask_q <= writedata[`SSIO_IRQ_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      readData_q <= 32'h0;
    else if (busHit && read)
    begin
      readData_q <= 32'h0;
      if (address == `SSIO_OFS_CTRL)
      begin
        readData_q[`SSIO_CTRL_AUTO] <= autoRestart_q;
      end
      else if (address == `SSIO_OFS_STATUS)
      begin
        readData_q[`SSIO_ST_OPER] <= (state_q == SSIO_OPER);
        readData_q[`SSIO_ST_FAULT] <= (state_q == SSIO_FAULT);
        readData_q[`SSIO_ST_BUS_READY] <= busReady_q;
        readData_q[`SSIO_ST_LINE] <= linePresent_q;
        readData_q[`SSIO_ST_CONTACT] <= contact_q;
        readData_q[`SSIO_ST_FAULT_NOW] <= faultNow;
      end
      else if (address == `SSIO_OFS_IRQ_STAT)
      begin
        readData_q[`SSIO_IRQ_W-1:0] <= irqStat_q;
      end
      else if (address == `SSIO_OFS_IRQ_MASK)
      begin
        readData_q[`SSIO_IRQ_W-1:0] <= irqMask_q;
      end
    end
  end

  // sticky events; a new event in the read cycle survives the clear
  always_comb
  begin
    irqStat_d = rdIrq ? '0 : irqStat_q;
    irqStat_d[`SSIO_IRQ_FAULT] = irqStat_d[`SSIO_IRQ_FAULT]
      || (state_q != SSIO_FAULT && state_d == SSIO_FAULT);
    irqStat_d[`SSIO_IRQ_LINE_LOST] = irqStat_d[`SSIO_IRQ_LINE_LOST]
      || (linePresent_q && !acLvl && lineCnt_q == LINE_OFF_CYC - 32'h1);
    irqStat_d[`SSIO_IRQ_CLEARED] = irqStat_d[`SSIO_IRQ_CLEARED]
      || (state_q == SSIO_FAULT && state_d == SSIO_OPER);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irqStat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irqStat_q <= irqStat_d;
      irq_q <= |(irqStat_d & irqMask_q);
    end
  end

  assign busReadyOutput = busReady_q;
  assign linePresentOutput = linePresent_q;
  assign faultIndicatorOutput = faultOut_q;
  assign readyToOperateContact = contact_q;
  assign highVoltageDcBusEnable = hvdcEn_q;
  assign readdata = readData_q;
  assign waitrequest = waitReq_q;
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_bus_ready_gate: assert property (
    (state_q != SSIO_OPER || faultNow) |=> !busReady_q)
    else $error("bus ready on outside clean operation");

  a_ready_drop_fault: assert property (
    (state_q == SSIO_OPER && faultNow) |=> ##1 (!busReady_q && !contact_q))
    else $error("bus ready or contact stayed on after fault");

  a_fault_out_on: assert property (
    (state_q == SSIO_FAULT) |=> (faultOut_q && !hvdcEn_q))
    else $error("fault output off or dc bus on in fault");

  a_contact_open_fault: assert property (
    faultOut_q |-> !contact_q)
    else $error("contact closed while fault shown");

  a_brake_trip: assert property (
    (state_q == SSIO_OPER && brakeLvl) |=> (state_q == SSIO_FAULT))
    else $error("brake overload did not trip to fault");

  a_clear_gated: assert property (
    (state_q == SSIO_OPER && clrIf.accept && !faultNow) |=> (state_q == SSIO_OPER))
    else $error("clear disturbed operation");

  a_fault_hold: assert property (
    (state_q == SSIO_FAULT && !anyClear) |=> (state_q == SSIO_FAULT))
    else $error("fault left without a clear");

  a_clear_persist: assert property (
    (state_q == SSIO_FAULT && faultNow) |=> (state_q == SSIO_FAULT))
    else $error("fault left while condition present");

  a_clear_resume: assert property (
    (state_q == SSIO_FAULT && anyClear && !faultNow) |=> (state_q == SSIO_OPER)
      ##1 contact_q)
    else $error("accepted clear did not resume");

  a_line_on: assert property (
    acLvl |=> linePresent_q)
    else $error("line present not on with ac detected");

  a_line_delay: assert property (
    (!acLvl && linePresent_q && lineCnt_q < LINE_OFF_CYC - 32'h1) |=> linePresent_q)
    else $error("line present dropped before the delay");

  a_line_off: assert property (
    (!acLvl && lineCnt_q == LINE_OFF_CYC - 32'h1) ##1 !acLvl |-> !linePresent_q [*2])
    else $error("line present not off after the delay");

  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> (!busReady_q && !faultOut_q && !linePresent_q && !contact_q))
    else $error("outputs active after reset");

  a_ack_single: assert property (
    !waitReq_q |=> waitReq_q)
    else $error("waitrequest low for more than one cycle");

  c_trip_and_clear: cover property (
    (state_q == SSIO_FAULT) ##[1:1000] (state_q == SSIO_OPER));
  c_brake_trip: cover property (
    (state_q == SSIO_OPER) && brakeLvl);
  c_line_lost: cover property (
    $fell(linePresent_q));
  c_irq_raised: cover property (
    $rose(irq_q));
  c_clear_pulse: cover property (
    $rose(clrIf.level));

endmodule : ssio_status_io

// ---- pkg/ssio_map.svh ----
// offsets, field positions and timing counts of the supply status i/o block
// assumes a 250 MHz core clock; counts are derived from that rate
`ifndef SSIO_MAP_SVH
`define SSIO_MAP_SVH

// core clock rate in kHz, so that a time in ms times this gives cycles
`define SSIO_CLK_KHZ 250000
// least width of a fault-clear pulse, in ms
`define SSIO_CLR_MIN_MS 100
// off delay of the line-present output after the ac line drops, in ms
`define SSIO_LINE_OFF_MS 20
`define SSIO_CLR_MIN_CYC (`SSIO_CLR_MIN_MS * `SSIO_CLK_KHZ)
`define SSIO_LINE_OFF_CYC (`SSIO_LINE_OFF_MS * `SSIO_CLK_KHZ)

// register byte offsets
`define SSIO_OFS_CTRL 4'h0
`define SSIO_OFS_STATUS 4'h4
`define SSIO_OFS_IRQ_STAT 4'h8
`define SSIO_OFS_IRQ_MASK 4'hc

// control fields
`define SSIO_CTRL_CLEAR 0
`define SSIO_CTRL_AUTO 1

// status fields
`define SSIO_ST_OPER 0
`define SSIO_ST_FAULT 1
`define SSIO_ST_BUS_READY 2
`define SSIO_ST_LINE 3
`define SSIO_ST_CONTACT 4
`define SSIO_ST_FAULT_NOW 5

// interrupt fields, same layout in status and mask
`define SSIO_IRQ_W 3
`define SSIO_IRQ_FAULT 0
`define SSIO_IRQ_LINE_LOST 1
`define SSIO_IRQ_CLEARED 2

// synchronised level pins of the top module
`define SSIO_PIN_N 3
`define SSIO_PIN_LINE 0
`define SSIO_PIN_FAULT 1
`define SSIO_PIN_BRAKE 2

`endif

// ---- pkg/ssio_pkg.sv ----
// types of the supply status i/o block
// assumes ssio_map.svh for all numbers
package ssio_pkg;

  typedef enum logic [2:0]
  {
    SSIO_INIT = 3'b001,
    SSIO_OPER = 3'b010,
    SSIO_FAULT = 3'b100
  } ssio_state_t;

endpackage : ssio_pkg

// ---- pkg/ssio_clr_if.sv ----
// carries the qualified fault-clear request from the pulse qualifier
// assumes both ends share the core clock
`timescale 1ns/10ps
interface ssio_clr_if;
  logic accept;
  logic level;

  modport qual (output accept, output level);
  modport user (input accept, input level);
endinterface : ssio_clr_if

// ---- core/ssio_pulse_qual.sv ----
// synchroniser and high-time counter for the fault-clear pin
// assumes an asynchronous pin and a synchronous active-high reset
`timescale 1ns/10ps
`include "ssio_map.svh"
module ssio_pulse_qual
  import ssio_pkg::*;
#(
  parameter int unsigned MIN_CYC = `SSIO_CLR_MIN_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // isolated pin
  input wire logic pinAsync,
  // qualified request
  ssio_clr_if.qual clr
);

  logic [2:0] sync_q;
  logic level_q;
  logic [31:0] cnt_q;
  logic accept_q;

  // stage 0 feeds only stage 1
  always_ff @(posedge clk)
  begin
    if (srst)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], pinAsync};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      level_q <= 1'b0;
    else if (sync_q[1] == sync_q[2])
      level_q <= sync_q[2];
  end

  // saturates so that one long pulse is accepted only once
  always_ff @(posedge clk)
  begin
    if (srst || !level_q)
      cnt_q <= 32'h0;
    else if (cnt_q != MIN_CYC)
      cnt_q <= cnt_q + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      accept_q <= 1'b0;
    else
      accept_q <= level_q && (cnt_q == MIN_CYC - 32'h1);
  end

  assign clr.accept = accept_q;
  assign clr.level = level_q;

  a_accept_width: assert property (@(posedge clk) disable iff (srst)
    accept_q |-> $past(level_q) && ($past(cnt_q) == MIN_CYC - 32'h1) && !$past(accept_q))
    else $error("clear accepted before the least width");

endmodule : ssio_pulse_qual

// ---- verification/ssio_ctrl_model.sv ----
// partner model: machine controller that pulses the fault-clear pin
// assumes the bench calls pulse() just after a rising edge of clk
`timescale 1ns/10ps
module ssio_ctrl_model
(
  // clock
  input wire logic clk,
  // fault-clear pin, idle low between pulses
  output logic faultClear
);
  initial faultClear = 1'b0;

  // width is in cycles; callers go below the minimum only to be refused
  task automatic pulse(input int unsigned cyc);
    faultClear <= 1'b1;
    repeat (cyc) @(posedge clk);
    faultClear <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : ssio_ctrl_model

// ---- verification/ssio_status_io_test.sv ----
// self-checking bench of the supply status i/o block
// assumes short counts: clear minimum 8 cycles, line off delay 6 cycles
`timescale 1ns/10ps
`include "ssio_map.svh"
module ssio_status_io_test;
  localparam int unsigned CLR_N = 8;
  localparam int unsigned OFF_N = 6;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic acLineDetect = 1'b0;
  logic faultDetect = 1'b0;
  logic brakeOverload = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic faultClear;
  logic busReadyOutput, linePresentOutput, faultIndicatorOutput;
  logic readyToOperateContact, highVoltageDcBusEnable, waitrequest, irq;
  logic [31:0] readdata;
  int err_count = 0;
  int num_checks = 0;

  ssio_status_io #(.CLR_MIN_CYC(CLR_N), .LINE_OFF_CYC(OFF_N)) u_ssio_status_io
  (
    .clk(clk), .srst(srst), .faultClearInput(faultClear), .acLineDetect(acLineDetect),
    .faultDetect(faultDetect), .brakeOverload(brakeOverload),
    .busReadyOutput(busReadyOutput), .linePresentOutput(linePresentOutput),
    .faultIndicatorOutput(faultIndicatorOutput),
    .readyToOperateContact(readyToOperateContact),
    .highVoltageDcBusEnable(highVoltageDcBusEnable), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq)
  );

  ssio_ctrl_model u_ssio_ctrl_model
  (
    .clk(clk),
    .faultClear(faultClear)
  );

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one avalon transfer, held until waitrequest is seen low; one idle cycle after
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    address <= adr;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chk("bus wait edges", 32'h2, 32'(n));
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, adr, d, unused);
  endtask : wr

  task automatic rdchk(input string what, input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0, d);
    chk(what, exp, d);
  endtask : rdchk

  // f high: fault shown, contact open, bus ready and dc bus off
  task automatic pins(input string what, input logic f);
    chk(what, 32'({~f, f, ~f, ~f}), 32'({busReadyOutput, faultIndicatorOutput,
      readyToOperateContact, highVoltageDcBusEnable}));
  endtask : pins

  task automatic t_reset();
    cyc(4);
    pins("pins after reset", 1'b0);
    rdchk("status oper", `SSIO_OFS_STATUS, 32'h15);
    rdchk("unmapped read", 4'h2, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_line();
    acLineDetect <= 1'b1;
    cyc(6);
    chk("line on", 32'h1, 32'(linePresentOutput));
    rdchk("status line", `SSIO_OFS_STATUS, 32'h1d);
    acLineDetect <= 1'b0;
    cyc(OFF_N);
    chk("line held", 32'h1, 32'(linePresentOutput));
    cyc(OFF_N + 2);
    chk("line off", 32'h0, 32'(linePresentOutput));
    chk("irq masked", 32'h0, 32'(irq));
    wr(`SSIO_OFS_IRQ_MASK, 32'h2);
    chk("irq unmasked", 32'h1, 32'(irq));
    rdchk("irq status", `SSIO_OFS_IRQ_STAT, 32'h2);
    chk("irq cleared", 32'h0, 32'(irq));
    rdchk("irq status empty", `SSIO_OFS_IRQ_STAT, 32'h0);
    rdchk("irq mask", `SSIO_OFS_IRQ_MASK, 32'h2);
    $display("test line done");
  endtask : t_line

  task automatic t_clr_idle();
    u_ssio_ctrl_model.pulse(CLR_N + 4);
    pins("pin clear in oper", 1'b0);
    wr(`SSIO_OFS_CTRL, 32'h1);
    rdchk("status sw clear in oper", `SSIO_OFS_STATUS, 32'h15);
    rdchk("no cleared event", `SSIO_OFS_IRQ_STAT, 32'h0);
    $display("test clear outside fault done");
  endtask : t_clr_idle

  task automatic t_fault();
    faultDetect <= 1'b1;
    cyc(8);
    pins("pins on fault", 1'b1);
    rdchk("status fault", `SSIO_OFS_STATUS, 32'h22);
    u_ssio_ctrl_model.pulse(CLR_N + 4);
    pins("clear with fault present", 1'b1);
    faultDetect <= 1'b0;
    cyc(8);
    pins("fault stays latched", 1'b1);
    u_ssio_ctrl_model.pulse(CLR_N - 2);
    pins("short pulse refused", 1'b1);
    u_ssio_ctrl_model.pulse(CLR_N + 4);
    cyc(2);
    pins("pin clear restores", 1'b0);
    rdchk("irq fault events", `SSIO_OFS_IRQ_STAT, 32'h5);
    $display("test fault done");
  endtask : t_fault

  task automatic t_brake();
    brakeOverload <= 1'b1;
    cyc(8);
    pins("brake overload", 1'b1);
    brakeOverload <= 1'b0;
    cyc(8);
    wr(`SSIO_OFS_CTRL, 32'h1);
    cyc(3);
    pins("sw clear restores", 1'b0);
    wr(`SSIO_OFS_CTRL, 32'h2);
    rdchk("ctrl auto", `SSIO_OFS_CTRL, 32'h2);
    faultDetect <= 1'b1;
    cyc(8);
    pins("fault with auto restart", 1'b1);
    faultDetect <= 1'b0;
    cyc(8);
    pins("auto restart", 1'b0);
    wr(`SSIO_OFS_CTRL, 32'h0);
    $display("test brake and auto done");
  endtask : t_brake

  initial
  begin
    cyc(2);
    chk("outputs in reset", 32'h1, 32'({busReadyOutput, linePresentOutput,
      faultIndicatorOutput, readyToOperateContact, highVoltageDcBusEnable, irq,
      waitrequest}));
    cyc(1);
    srst <= 1'b0;
    t_reset();
    t_line();
    t_clr_idle();
    t_fault();
    t_brake();
    wrap_up();
  end

  // the tests need well under 1000 cycles
  initial
  begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule : ssio_status_io_test
